// [core/dmsp_map.vh]
`ifndef DMSP_MAP_VH
`define DMSP_MAP_VH
// strap level that selects the i2c slave
`define DMSP_MODE_I2C 1'b1
// i2c slave address, upper six bits (arbitrary default)
`define DMSP_I2C_ADDR_HI 6'h2a
// spi command bit 7: 1 = read
`define DMSP_CMD_RD_BIT 7
`define DMSP_ADDR_W 7
`define DMSP_DATA_W 8
`define DMSP_REG_DEPTH 128
`define DMSP_SR_RESET 8'h00
`endif

// [core/dmsp_port.v]
`include "dmsp_map.vh"
`timescale 1ns/1ps
`default_nettype none
module dmsp_port (
  input wire clock,
  input wire rst_b,
  input wire ce,
  input wire i2c_en,
  input wire clk_pin_in,
  output wire clk_pin_out,
  output wire clk_pin_oe,
  input wire data_pin_in,
  output wire data_pin_out,
  output wire data_pin_oe,
  output reg so,
  output reg so_oe,
  input wire sel_pin,
  output wire int_b_out,
  output wire int_b_oe,
  input wire [7:0] status_in,
  input wire [7:0] status_enable,
  output reg [6:0] reg_addr,
  output reg [7:0] reg_wdata,
  output reg reg_wr
);
  localparam ST_IDLE = 5'h01;
  localparam ST_ADDR = 5'h02;
  localparam ST_ACK = 5'h04;
  localparam ST_DATA = 5'h08;
  localparam ST_RACK = 5'h10;

  reg [1:0] sy_clk, sy_dat, sy_sel;
  reg clk_d, dat_d;
  reg mode_i2c;
  reg strap_taken;
  reg [7:0] sr;
  reg [3:0] bitcnt;
  reg [4:0] state;
  reg rd_mode, first_byte;
  reg sda_drive;
  reg [7:0] status_d;
  reg [7:0] pending;
  wire [7:0] rdata;
  reg [6:0] raddr;

  wire c = sy_clk[1];
  wire d = sy_dat[1];
  wire rise = c & ~clk_d;
  wire fall = ~c & clk_d;
  wire start = c & dat_d & ~d;
  wire stop = c & ~dat_d & d;
  wire cs_act = ~sy_sel[1];
  wire [6:0] my_addr = {`DMSP_I2C_ADDR_HI, sy_sel[1]};
  // first bit of each read data byte services the pending events, in either mode
  wire rd_clr = mode_i2c ? (state == ST_DATA && rd_mode && bitcnt == 4'h0 && (fall | rise)) :
    (cs_act && rise && rd_mode && !first_byte && bitcnt == 4'h0);

  dmsp_regmem u_mem (
    .clock(clock),
    .ce(ce),
    .we(reg_wr),
    .waddr(reg_addr),
    .wdata(reg_wdata),
    .raddr(raddr),
    .rdata(rdata)
  );

  always @* begin
    raddr = reg_addr;
  end

  // clock pin is sck or scl input only; device never stretches scl
  assign clk_pin_out = 1'b0;
  assign clk_pin_oe = 1'b0;
  assign data_pin_out = 1'b0;
  assign data_pin_oe = mode_i2c & sda_drive;
  assign int_b_out = 1'b0;
  assign int_b_oe = |pending;

  always @(posedge clock) begin
    if (!rst_b) begin
      sy_clk <= 2'h0;
      sy_dat <= 2'h3;
      sy_sel <= 2'h3;
      clk_d <= 1'b0;
      dat_d <= 1'b1;
      mode_i2c <= 1'b1;
      strap_taken <= 1'b0;
      sr <= `DMSP_SR_RESET;
      bitcnt <= 4'h0;
      state <= ST_IDLE;
      rd_mode <= 1'b0;
      first_byte <= 1'b1;
      sda_drive <= 1'b0;
      so <= 1'b0;
      so_oe <= 1'b0;
      reg_addr <= 7'h00;
      reg_wdata <= 8'h00;
      reg_wr <= 1'b0;
      status_d <= 8'h00;
      pending <= 8'h00;
    end else if (ce) begin
      sy_clk <= {sy_clk[0], clk_pin_in};
      sy_dat <= {sy_dat[0], data_pin_in};
      sy_sel <= {sy_sel[0], sel_pin};
      clk_d <= c;
      dat_d <= d;
      reg_wr <= 1'b0;
      status_d <= status_in;
      // strap caught once after reset release, then static
      if (!strap_taken) begin
        mode_i2c <= i2c_en;
        strap_taken <= 1'b1;
      end
      // set wins over a read-clear in the same cycle
      // no set on the first edge: status_d holds its reset value, not the last status
      pending <= (pending & ~{8{rd_clr}}) |
        ({8{strap_taken}} & (status_in ^ status_d) & status_enable);
      if (!strap_taken) begin
        state <= ST_IDLE;
      end else if (!mode_i2c) begin
        so_oe <= cs_act;
        if (!cs_act) begin
          state <= ST_IDLE;
          bitcnt <= 4'h0;
          first_byte <= 1'b1;
        end else begin
          if (rise) begin
            sr <= {sr[6:0], d};
            bitcnt <= bitcnt + 4'h1;
            if (bitcnt == 4'h7) begin
              bitcnt <= 4'h0;
              if (first_byte) begin
                rd_mode <= sr[6];
                reg_addr <= {sr[5:0], d};
                first_byte <= 1'b0;
              end else if (!rd_mode) begin
                reg_wdata <= {sr[6:0], d};
                reg_wr <= 1'b1;
              end else begin
                reg_addr <= reg_addr + 7'h01;
              end
            end
          end
          if (fall) begin
            so <= rd_mode & ~first_byte ? rdata[3'h7 - bitcnt[2:0]] : 1'b0;
          end
        end
      end else begin
        so_oe <= 1'b0;
        so <= 1'b0;
        if (start) begin
          state <= ST_ADDR;
          bitcnt <= 4'h0;
          first_byte <= 1'b1;
          sda_drive <= 1'b0;
        end else if (stop) begin
          state <= ST_IDLE;
          sda_drive <= 1'b0;
        end else begin
          case (state)
            ST_IDLE: begin
              sda_drive <= 1'b0;
            end
            ST_ADDR: begin
              if (rise) begin
                sr <= {sr[6:0], d};
                bitcnt <= bitcnt + 4'h1;
              end
              if (fall && bitcnt == 4'h8) begin
                if (sr[7:1] == my_addr) begin
                  rd_mode <= sr[0];
                  sda_drive <= 1'b1;
                  state <= ST_ACK;
                end else begin
                  state <= ST_IDLE;
                end
              end
            end
            ST_ACK: begin
              if (fall) begin
                bitcnt <= 4'h0;
                state <= ST_DATA;
                sda_drive <= rd_mode & ~rdata[7];
              end
            end
            ST_DATA: begin
              if (rise) begin
                sr <= {sr[6:0], d};
                bitcnt <= bitcnt + 4'h1;
              end
              if (fall) begin
                if (bitcnt == 4'h8) begin
                  if (rd_mode) begin
                    sda_drive <= 1'b0;
                    reg_addr <= reg_addr + 7'h01;
                    state <= ST_RACK;
                  end else begin
                    if (first_byte) begin
                      reg_addr <= sr[6:0];
                      first_byte <= 1'b0;
                    end else begin
                      reg_wdata <= sr;
                      reg_wr <= 1'b1;
                    end
                    sda_drive <= 1'b1;
                    state <= ST_ACK;
                  end
                end else if (rd_mode) begin
                  sda_drive <= ~rdata[3'h7 - bitcnt[2:0]];
                end
              end
            end
            ST_RACK: begin
              if (rise) begin
                state <= d ? ST_IDLE : ST_ACK;
              end
            end
            default: begin
              state <= ST_IDLE;
            end
          endcase
        end
      end
    end
  end
endmodule // dmsp_port
`default_nettype wire

// [core/dmsp_regmem.v]
`timescale 1ns/1ps
`default_nettype none
module dmsp_regmem (
  input wire clock,
  input wire ce,
  input wire we,
  input wire [6:0] waddr,
  input wire [7:0] wdata,
  input wire [6:0] raddr,
  output reg [7:0] rdata
);
  reg [7:0] mem [0:127];
  always @(posedge clock) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule // dmsp_regmem
`default_nettype wire

// [verification/dmsp_host.sv]
`timescale 1ns/1ps
`default_nettype none
module dmsp_host (
  output logic sck,
  output logic cs_b,
  output logic si,
  input wire logic so
);
  logic [15:0] rx;
  initial begin
    sck = 0;
    cs_b = 1;
    si = 0;
  end
  // sel low keeps cs released while the clock still runs
  task automatic xfer(input logic [15:0] tx, input logic sel);
    #5 cs_b = !sel;
    for (int i = 15; i >= 0; i--) begin
      si = tx[i];
      #100 sck = 1;
      #100 rx[i] = so;
      sck = 0;
    end
    #100 cs_b = 1;
    si = !si;
    #200;
  endtask
  // i2c write: start, 27 bits with ack slots released high, stop
  task automatic i2c_wr(input logic [26:0] tx);
    si = 1;
    sck = 1;
    #100 si = 0;
    #100 sck = 0;
    for (int i = 26; i >= 0; i--) begin
      #50 si = tx[i];
      #50 sck = 1;
      #100 sck = 0;
    end
    #50 si = 0;
    #50 sck = 1;
    #100 si = 1;
    #200;
  endtask
endmodule // dmsp_host
`default_nettype wire

// [verification/dmsp_port_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module dmsp_chk (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic i2c_en,
  input wire logic sel_pin,
  input wire logic clk_pin_oe,
  input wire logic data_pin_out,
  input wire logic data_pin_oe,
  input wire logic so_oe,
  input wire logic int_b_out,
  input wire logic int_b_oe,
  input wire logic [7:0] status_in,
  input wire logic [7:0] status_enable
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence cs_idle;
    sel_pin [*4];
  endsequence
  a_scl_free: assert property (!clk_pin_oe) else $error("scl oe");
  a_int_od: assert property (!int_b_out) else $error("int high");
  a_sda_od: assert property (!data_pin_out) else $error("sda high");
  a_si_spi: assert property (!i2c_en |-> !data_pin_oe) else $error("si driven");
  a_so_i2c: assert property (i2c_en |-> !so_oe) else $error("so in i2c");
  a_so_idle: assert property (cs_idle |-> !so_oe) else $error("so no cs");
  a_int_set: assert property ($changed(status_in & status_enable) |-> ##[1:6] int_b_oe) else $error("no int");
  a_int_hold: assert property ($fell(int_b_oe) && !i2c_en |-> !sel_pin) else $error("int dropped");
endmodule // dmsp_chk
bind dmsp_port dmsp_chk u_chk (.*);
`default_nettype wire

// [verification/tb_dmsp_port.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_dmsp_port;
  logic clock = 0;
  logic rst_b = 0;
  logic i2c_en = 0;
  logic [7:0] status_in = 0;
  logic sck, cs_b, si, so, so_oe, data_pin_oe, int_b_oe, reg_wr;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [15:0] wd;
  int num_errors, compares;
  dmsp_host i_host (.*);
  dmsp_port i_dut (.*, .ce(1'b1), .clk_pin_in(sck), .clk_pin_out(), .clk_pin_oe(), .data_pin_in(si & !data_pin_oe),
    .data_pin_out(), .sel_pin(cs_b), .int_b_out(), .status_enable(8'h0f));
  initial forever #12.5 clock = ~clock;
  always @(posedge clock) if (reg_wr) wd <= {1'b0, reg_addr, reg_wdata};
  task automatic chk(input logic [15:0] got, exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t %h %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic rst(input logic m);
    @(posedge clock);
    rst_b <= 0;
    i2c_en <= m;
    repeat (8) @(posedge clock);
    rst_b <= 1;
  endtask
  task automatic t_spi;
    i_host.xfer(16'h05a5, 1);
    chk(wd, 16'h05a5);
    i_host.xfer(16'h8500, 1);
    chk({8'h0, i_host.rx[7:0]}, 16'h00a5);
    i_host.xfer(16'h0733, 0);
    chk(wd, 16'h05a5);
  endtask
  task automatic t_irq;
    @(posedge clock);
    status_in <= 8'h10;
    repeat (8) @(posedge clock);
    chk(int_b_oe, 0);
    status_in <= 8'h11;
    repeat (8) @(posedge clock);
    chk(int_b_oe, 1);
    i_host.xfer(16'h0633, 1);
    chk(int_b_oe, 1);
    i_host.xfer(16'h8600, 1);
    chk({8'h0, i_host.rx[7:0]}, 16'h0033);
    chk(int_b_oe, 0);
  endtask
  task automatic t_i2c;
    rst(1);
    i_host.xfer(16'h0777, 1);
    chk(wd, 16'h0633);
    i_host.i2c_wr({8'haa, 1'b1, 8'h09, 1'b1, 8'h5c, 1'b1});
    chk(wd, 16'h095c);
    i_host.i2c_wr({8'ha8, 1'b1, 8'h0a, 1'b1, 8'h11, 1'b1});
    chk(wd, 16'h095c);
  endtask
  initial begin
    rst(0);
    t_spi;
    t_irq;
    t_i2c;
    final_report;
  end
  initial begin
    #200000;
    num_errors++;
    final_report;
  end
endmodule // tb_dmsp_port
`default_nettype wire
